//--- core/lap_lookup_access.sv
`include "lap_regs.svh"

module lap_lookup_access (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic [15:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o
);

    // registers are big-endian: the lowest byte address holds bits 31:24
    logic [13:0]                 word_sel;
    logic [1:0]                  lane;
    logic                        hit_key_hi;
    logic                        hit_key_lo;
    logic                        hit_alu_ctrl;
    logic                        hit_sm_ctrl;
    logic                        hit_ent1;
    logic                        hit_ent2;
    logic                        hit_ent3;
    logic                        hit_ent4;
    logic                        rd_last_byte;

    logic                        key_rsv_r;
    logic [6:0]                  key_filter_r;
    logic [15:0]                 key_mac_hi_r;
    logic [31:0]                 key_lo_r;

    logic                        alu_go_r;
    lap_pkg::lap_action_type     alu_action_r;
    logic                        alu_direct_r;
    logic [1:0]                  alu_rsv_r;
    logic [13:0]                 valid_count_r;
    logic                        srch_valid_r;
    logic                        srch_end_r;

    logic                        sm_go_r;
    logic [5:0]                  sm_index_r;
    logic [4:0]                  sm_rsv_r;
    logic                        sm_table_r;
    logic                        sm_read_r;

    logic [31:0]                 ent1_r;
    logic [31:0]                 ent2_r;
    logic [31:0]                 ent3_r;
    logic [31:0]                 ent4_r;

    lap_pkg::lap_state_type      state_r;
    logic [`LAP_ALU_ROW_W-1:0]   scan_row_r;
    logic [13:0]                 scan_count_r;
    logic [7:0]                  rdata_r;

    logic [127:0]                alu_mem [0:(1<<`LAP_ALU_ROW_W)-1];
    logic [127:0]                sta_mem [0:(1<<`LAP_STA_ROW_W)-1];
    logic [31:0]                 rmc_mem [0:(1<<`LAP_RMC_ROW_W)-1];

    logic [31:0]                 key_hi_word;
    logic [31:0]                 alu_ctrl_word;
    logic [31:0]                 sm_ctrl_word;
    logic [31:0]                 key_hi_nxt;
    logic [31:0]                 key_lo_nxt;
    logic [31:0]                 alu_ctrl_nxt;
    logic [31:0]                 sm_ctrl_nxt;
    logic [127:0]                ent_all;
    logic [`LAP_ALU_ROW_W-1:0]   hash_row;
    logic [`LAP_ALU_ROW_W-1:0]   alu_row;
    logic [`LAP_STA_ROW_W-1:0]   sta_row;
    logic [`LAP_RMC_ROW_W-1:0]   rmc_row;
    logic                        alu_start;
    logic                        sm_start;
    logic                        alu_done;
    logic                        scan_hit;
    logic                        scan_last;

    function automatic logic [31:0] lap_merge(input logic [31:0] old,
                                              input logic [1:0]  ln,
                                              input logic [7:0]  d);
        logic [31:0] res;
        res = old;
        res[ln*8 +: 8] = d;
        return res;
    endfunction

    // simple xor fold of {filter identifier, mac}; stands in for the switch hash
    function automatic logic [`LAP_ALU_ROW_W-1:0] lap_hash(input logic [54:0] key);
        logic [59:0]               padded;
        logic [`LAP_ALU_ROW_W-1:0] h;
        padded = {5'b0_0000, key};
        h = `LAP_RST_ROW;
        for (int i = 0; i < 5; i++) begin
            h = h ^ padded[i*`LAP_ALU_ROW_W +: `LAP_ALU_ROW_W];
        end
        return h;
    endfunction

    assign word_sel     = reg_addr_i[15:2];
    assign lane         = 2'b11 - reg_addr_i[1:0];
    assign hit_key_hi   = (word_sel == `LAP_OFS_KEY_HIGH >> 2);
    assign hit_key_lo   = (word_sel == `LAP_OFS_KEY_LOW >> 2);
    assign hit_alu_ctrl = (word_sel == `LAP_OFS_ALU_CTRL >> 2);
    assign hit_sm_ctrl  = (word_sel == `LAP_OFS_SM_CTRL >> 2);
    assign hit_ent1     = (word_sel == `LAP_OFS_ENTRY1 >> 2);
    assign hit_ent2     = (word_sel == `LAP_OFS_ENTRY2 >> 2);
    assign hit_ent3     = (word_sel == `LAP_OFS_ENTRY3 >> 2);
    assign hit_ent4     = (word_sel == `LAP_OFS_ENTRY4 >> 2);
    assign rd_last_byte = reg_rd_i && (reg_addr_i == `LAP_OFS_ENTRY4_LAST);

    assign key_hi_word = {key_rsv_r, 8'h00, key_filter_r, key_mac_hi_r};

    // entry ready or search ended
    // the ended flag is not set by reset, so a freshly reset part reads zero here until a search hits or ends
    assign alu_ctrl_word = {2'b00, valid_count_r, 8'h00, alu_go_r, srch_valid_r,
                            srch_valid_r | srch_end_r, alu_rsv_r, alu_direct_r,
                            alu_action_r};
    assign sm_ctrl_word  = {10'h000, sm_index_r, 8'h00, sm_go_r, sm_rsv_r,
                            sm_table_r, sm_read_r};

    assign key_hi_nxt   = lap_merge(key_hi_word, lane, reg_wdata_i);
    assign key_lo_nxt   = lap_merge(key_lo_r, lane, reg_wdata_i);
    assign alu_ctrl_nxt = lap_merge(alu_ctrl_word, lane, reg_wdata_i);
    assign sm_ctrl_nxt  = lap_merge(sm_ctrl_word, lane, reg_wdata_i);
    assign ent_all      = {ent1_r, ent2_r, ent3_r, ent4_r};

    // key from both index words hashes the row
    assign hash_row = lap_hash({key_filter_r, key_mac_hi_r, key_lo_r});
    // low twelve key bits as direct row
    assign alu_row  = alu_direct_r ? key_lo_r[`LAP_DIRECT_MSB:0] : hash_row;
    // static table uses low four index bits
    assign sta_row  = sm_index_r[`LAP_SM_STA_IDX_MSB-`LAP_SM_IDX_LSB:0];
    assign rmc_row  = sm_index_r;

    // lookup table has priority when both go bits are pending
    assign alu_start = (state_r == lap_pkg::lap_st_idle) && alu_go_r;
    assign sm_start  = (state_r == lap_pkg::lap_st_idle) && !alu_go_r && sm_go_r;
    assign alu_done  = (alu_start && alu_action_r != lap_pkg::lap_act_search) ||
                       (state_r == lap_pkg::lap_st_finish);
    assign scan_hit  = (state_r == lap_pkg::lap_st_scan) &&
                       alu_mem[scan_row_r][96+`LAP_ENTRY_VALID_BIT];
    assign scan_last = (scan_row_r == `LAP_ALU_LAST_ROW);

    // key words
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            key_rsv_r    <= 1'b0;
            key_filter_r <= 7'h00;
            key_mac_hi_r <= 16'h0000;
            key_lo_r     <= `LAP_RST_WORD;
        end else if (reg_wr_i) begin
            if (hit_key_hi) begin
                // filter identifier and upper mac bits
                key_rsv_r    <= key_hi_nxt[`LAP_KEY_RSV_BIT];
                key_filter_r <= key_hi_nxt[`LAP_KEY_FILTER_MSB:`LAP_KEY_FILTER_LSB];
                key_mac_hi_r <= key_hi_nxt[`LAP_KEY_MAC_MSB:`LAP_KEY_MAC_LSB];
            end
            if (hit_key_lo) begin
                key_lo_r <= key_lo_nxt;
            end
        end
    end

    // lookup control; writes while busy are dropped so the action cannot change mid-flight
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            alu_go_r     <= 1'b0;
            alu_action_r <= lap_pkg::lap_act_nop;
            alu_direct_r <= 1'b0;
            alu_rsv_r    <= 2'b00;
        end else if (reg_wr_i && hit_alu_ctrl && !alu_go_r) begin
            alu_go_r     <= alu_ctrl_nxt[`LAP_ALU_GO_BIT];
            alu_action_r <= lap_pkg::lap_action_type'(
                            alu_ctrl_nxt[`LAP_ALU_ACT_MSB:`LAP_ALU_ACT_LSB]);
            alu_direct_r <= alu_ctrl_nxt[`LAP_ALU_DIRECT_BIT];
            alu_rsv_r    <= alu_ctrl_nxt[`LAP_ALU_RSV_MSB:`LAP_ALU_RSV_LSB];
        end else if (alu_done) begin
            alu_go_r <= 1'b0;
        end
    end

    // static / reserved multicast control
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sm_go_r    <= 1'b0;
            sm_index_r <= 6'h00;
            sm_rsv_r   <= 5'h00;
            sm_table_r <= 1'b0;
            sm_read_r  <= 1'b0;
        end else if (reg_wr_i && hit_sm_ctrl && !sm_go_r) begin
            sm_go_r    <= sm_ctrl_nxt[`LAP_SM_GO_BIT];
            sm_index_r <= sm_ctrl_nxt[`LAP_SM_IDX_MSB:`LAP_SM_IDX_LSB];
            sm_rsv_r   <= sm_ctrl_nxt[`LAP_SM_RSV_MSB:`LAP_SM_RSV_LSB];
            sm_table_r <= sm_ctrl_nxt[`LAP_SM_TABLE_BIT];
            sm_read_r  <= sm_ctrl_nxt[`LAP_SM_READ_BIT];
        end else if (sm_start) begin
            // go self-clears after the one-cycle access
            sm_go_r <= 1'b0;
        end
    end

    // search engine
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r       <= lap_pkg::lap_st_idle;
            scan_row_r    <= `LAP_RST_ROW;
            scan_count_r  <= `LAP_RST_COUNT;
            srch_valid_r  <= 1'b0;
            srch_end_r    <= 1'b0;
            valid_count_r <= `LAP_RST_COUNT;
        end else begin
            case (state_r)
                lap_pkg::lap_st_idle: begin
                    if (alu_start && alu_action_r == lap_pkg::lap_act_search) begin
                        scan_row_r   <= `LAP_RST_ROW;
                        scan_count_r <= `LAP_RST_COUNT;
                        srch_end_r   <= 1'b0;
                        state_r      <= lap_pkg::lap_st_scan;
                    end
                end
                lap_pkg::lap_st_scan: begin
                    if (scan_hit) begin
                        srch_valid_r <= 1'b1;
                        scan_count_r <= 14'(scan_count_r + 14'h0001);
                        state_r      <= lap_pkg::lap_st_hold;
                    end else if (scan_last) begin
                        state_r <= lap_pkg::lap_st_finish;
                    end else begin
                        scan_row_r <= 12'(scan_row_r + 12'h001);
                    end
                end
                lap_pkg::lap_st_hold: begin
                    // last entry byte read releases the entry
                    if (rd_last_byte) begin
                        srch_valid_r <= 1'b0;
                        if (scan_last) begin
                            state_r <= lap_pkg::lap_st_finish;
                        end else begin
                            scan_row_r <= 12'(scan_row_r + 12'h001);
                            state_r    <= lap_pkg::lap_st_scan;
                        end
                    end
                end
                lap_pkg::lap_st_finish: begin
                    valid_count_r <= scan_count_r;
                    srch_end_r    <= 1'b1;
                    state_r       <= lap_pkg::lap_st_idle;
                end
                default: begin
                    state_r <= lap_pkg::lap_st_idle;
                end
            endcase
        end
    end

    // table memories
    always_ff @(posedge ref_clk_i) begin
        // write stores entry words before go clears
        if (alu_start && alu_action_r == lap_pkg::lap_act_write) begin
            alu_mem[alu_row] <= ent_all;
        end
        if (sm_start && !sm_read_r) begin
            if (sm_table_r) begin
                rmc_mem[rmc_row] <= ent2_r;
            end else begin
                sta_mem[sta_row] <= ent_all;
            end
        end
    end

    // entry words; hardware loads win over a host write in the same cycle
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ent1_r <= `LAP_RST_WORD;
            ent2_r <= `LAP_RST_WORD;
            ent3_r <= `LAP_RST_WORD;
            ent4_r <= `LAP_RST_WORD;
        end else if (scan_hit) begin
            {ent1_r, ent2_r, ent3_r, ent4_r} <= alu_mem[scan_row_r];
        end else if (alu_start && alu_action_r == lap_pkg::lap_act_read) begin
            // read loads entry words before go clears
            {ent1_r, ent2_r, ent3_r, ent4_r} <= alu_mem[alu_row];
        end else if (sm_start && sm_read_r) begin
            // multicast rows touch only word two
            if (sm_table_r) begin
                ent2_r <= rmc_mem[rmc_row];
            end else begin
                {ent1_r, ent2_r, ent3_r, ent4_r} <= sta_mem[sta_row];
            end
        end else if (reg_wr_i) begin
            if (hit_ent1) begin
                ent1_r <= lap_merge(ent1_r, lane, reg_wdata_i);
            end
            if (hit_ent2) begin
                ent2_r <= lap_merge(ent2_r, lane, reg_wdata_i);
            end
            if (hit_ent3) begin
                ent3_r <= lap_merge(ent3_r, lane, reg_wdata_i);
            end
            if (hit_ent4) begin
                ent4_r <= lap_merge(ent4_r, lane, reg_wdata_i);
            end
        end
    end

    // read data, one cycle after the strobe; unmapped bytes read zero
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_r <= 8'h00;
        end else if (reg_rd_i) begin
            if (hit_key_hi) begin
                rdata_r <= key_hi_word[lane*8 +: 8];
            end else if (hit_key_lo) begin
                rdata_r <= key_lo_r[lane*8 +: 8];
            end else if (hit_alu_ctrl) begin
                rdata_r <= alu_ctrl_word[lane*8 +: 8];
            end else if (hit_sm_ctrl) begin
                rdata_r <= sm_ctrl_word[lane*8 +: 8];
            end else if (hit_ent1) begin
                rdata_r <= ent1_r[lane*8 +: 8];
            end else if (hit_ent2) begin
                rdata_r <= ent2_r[lane*8 +: 8];
            end else if (hit_ent3) begin
                rdata_r <= ent3_r[lane*8 +: 8];
            end else if (hit_ent4) begin
                rdata_r <= ent4_r[lane*8 +: 8];
            end else begin
                rdata_r <= 8'h00;
            end
        end
    end

    assign reg_rdata_o = rdata_r;

endmodule

//--- core/lap_regs.svh
`ifndef LAP_REGS_SVH
`define LAP_REGS_SVH

// byte offsets of the register words
`define LAP_OFS_KEY_HIGH     16'h0410
`define LAP_OFS_KEY_LOW      16'h0414
`define LAP_OFS_ALU_CTRL     16'h0418
`define LAP_OFS_SM_CTRL      16'h041C
`define LAP_OFS_ENTRY1       16'h0420
`define LAP_OFS_ENTRY2       16'h0424
`define LAP_OFS_ENTRY3       16'h0428
`define LAP_OFS_ENTRY4       16'h042C
// last byte of entry word 4; reading it releases the search
`define LAP_OFS_ENTRY4_LAST  16'h042F

// key high word fields
`define LAP_KEY_RSV_BIT      31
`define LAP_KEY_FILTER_MSB   22
`define LAP_KEY_FILTER_LSB   16
`define LAP_KEY_MAC_MSB      15
`define LAP_KEY_MAC_LSB      0

// address lookup control fields
`define LAP_ALU_CNT_MSB      29
`define LAP_ALU_CNT_LSB      16
`define LAP_ALU_GO_BIT       7
`define LAP_ALU_VALID_BIT    6
`define LAP_ALU_EITHER_BIT   5
`define LAP_ALU_RSV_MSB      4
`define LAP_ALU_RSV_LSB      3
`define LAP_ALU_DIRECT_BIT   2
`define LAP_ALU_ACT_MSB      1
`define LAP_ALU_ACT_LSB      0

// static / reserved multicast control fields
`define LAP_SM_IDX_MSB       21
`define LAP_SM_IDX_LSB       16
`define LAP_SM_STA_IDX_MSB   19
`define LAP_SM_GO_BIT        7
`define LAP_SM_RSV_MSB       6
`define LAP_SM_RSV_LSB       2
`define LAP_SM_TABLE_BIT     1
`define LAP_SM_READ_BIT      0

// table geometry
`define LAP_ALU_ROW_W        12
`define LAP_ALU_LAST_ROW     12'hFFF
`define LAP_STA_ROW_W        4
`define LAP_RMC_ROW_W        6
`define LAP_DIRECT_MSB       11
// entry word 1 bit that marks a lookup row as valid
`define LAP_ENTRY_VALID_BIT  31

// reset values
`define LAP_RST_WORD         32'h0000_0000
`define LAP_RST_COUNT        14'h0000
`define LAP_RST_ROW          12'h000

`endif

//--- core/lap_pkg.sv
package lap_pkg;

    typedef enum logic [1:0] {
        lap_st_idle   = 2'b00,
        lap_st_scan   = 2'b01,
        lap_st_hold   = 2'b11,
        lap_st_finish = 2'b10
    } lap_state_type;

    typedef enum logic [1:0] {
        lap_act_nop    = 2'b00,
        lap_act_write  = 2'b01,
        lap_act_read   = 2'b10,
        lap_act_search = 2'b11
    } lap_action_type;

endpackage

//--- dv/lap_lookup_access_monitor.sv
module lap_lookup_access_monitor (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [15:0] reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic [7:0]  reg_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] key_low_r [4];
    logic [7:0] key_exp;
    logic       mapped;
    logic       rd_ctrl;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    assign mapped  = (reg_addr_i >= 16'h0410) && (reg_addr_i <= 16'h042F);
    assign rd_ctrl = reg_rd_i && (reg_addr_i == 16'h041B);
    assign key_exp = key_low_r[reg_addr_i[1:0]];

    // shadow of the plain key word; the engine never writes it, so it must echo
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            key_low_r <= '{default: 8'h00};
        end else if (reg_wr_i && (reg_addr_i[15:2] == 14'h0105)) begin
            key_low_r[reg_addr_i[1:0]] <= reg_wdata_i;
        end
    end

    a_key_low_echo: assert property (
        reg_rd_i && (reg_addr_i[15:2] == 14'h0105) |=> reg_rdata_o == $past(key_exp))
        else $error("key low byte read differs from last write");
    a_either_flag: assert property (
        rd_ctrl |=> (!reg_rdata_o[6] || reg_rdata_o[5]) &&
                    (!reg_rdata_o[5] || reg_rdata_o[6] || !reg_rdata_o[7]))
        else $error("combined flag not ready or ended");
    a_ready_when_busy: assert property (
        rd_ctrl |=> !(reg_rdata_o[6] && !reg_rdata_o[7]))
        else $error("ready flag set with go bit clear");
    a_count_top_zero: assert property (
        reg_rd_i && (reg_addr_i == 16'h0418) |=> reg_rdata_o[7:6] == 2'b00)
        else $error("bits above the count not zero");
    a_ctrl_rsv_zero: assert property (
        reg_rd_i && (reg_addr_i == 16'h041A) |=> reg_rdata_o == 8'h00)
        else $error("lookup control middle byte not zero");
    a_index_rsv_zero: assert property (
        reg_rd_i && ((reg_addr_i == 16'h041C) || (reg_addr_i == 16'h041E))
        |=> reg_rdata_o == 8'h00)
        else $error("static control reserved byte not zero");
    a_index_width: assert property (
        reg_rd_i && (reg_addr_i == 16'h041D) |=> reg_rdata_o[7:6] == 2'b00)
        else $error("static index wider than six bits");
    a_key_high_rsv: assert property (
        reg_rd_i && (reg_addr_i == 16'h0410) |=> reg_rdata_o[6:0] == 7'h00)
        else $error("key high reserved bits not zero");
    a_unmapped_zero: assert property (
        reg_rd_i && !mapped |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (
        !reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read byte changed without a read");

    c_entry_ready: cover property (rd_ctrl ##1 reg_rdata_o[6]);
    c_static_go: cover property (reg_wr_i && (reg_addr_i == 16'h041F) && reg_wdata_i[7]);
    c_release: cover property (reg_rd_i && (reg_addr_i == 16'h042F));
endmodule

bind lap_lookup_access lap_lookup_access_monitor u_monitor (
    .ref_clk_i   (ref_clk_i),
    .rst_b_i     (rst_b_i),
    .reg_addr_i  (reg_addr_i),
    .reg_wr_i    (reg_wr_i),
    .reg_rd_i    (reg_rd_i),
    .reg_wdata_i (reg_wdata_i),
    .reg_rdata_o (reg_rdata_o)
);

//--- dv/lap_lookup_access_test.sv
`define CHK(nm, e, g) \
    begin \
        comparisons++; \
        if ((g) !== (e)) begin \
            n_mismatch++; \
            $display("[FAIL] %s expected %h seen %h", nm, e, g); \
        end \
    end

module lap_lookup_access_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk_i   = 1'b0;
    logic        rst_b_i     = 1'b0;
    logic [15:0] reg_addr_i  = 16'h0000;
    logic        reg_wr_i    = 1'b0;
    logic        reg_rd_i    = 1'b0;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic [7:0]  reg_rdata_o;
    int          n_mismatch  = 0;
    int          comparisons = 0;
    int          hits;
    logic [31:0] w;
    logic [7:0]  b;
    logic [31:0] exp_e [4];
    logic [11:0] rows [3] = '{12'h000, 12'h5A5, 12'hFFF};

    always #25 ref_clk_i = ~ref_clk_i;

    lap_lookup_access DUT (
        .ref_clk_i   (ref_clk_i),
        .rst_b_i     (rst_b_i),
        .reg_addr_i  (reg_addr_i),
        .reg_wr_i    (reg_wr_i),
        .reg_rd_i    (reg_rd_i),
        .reg_wdata_i (reg_wdata_i),
        .reg_rdata_o (reg_rdata_o)
    );

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wr8(input logic [15:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        reg_addr_i  = a;
        reg_wdata_i = d;
        reg_wr_i    = 1'b1;
        @(negedge ref_clk_i);
        reg_wr_i    = 1'b0;
    endtask

    // the extra idle cycle covers either registering edge of the read byte
    task automatic rd8(input logic [15:0] a, output logic [7:0] d);
        @(negedge ref_clk_i);
        reg_addr_i = a;
        reg_rd_i   = 1'b1;
        @(negedge ref_clk_i);
        reg_rd_i   = 1'b0;
        @(negedge ref_clk_i);
        d = reg_rdata_o;
    endtask

    // words are big-endian: the lowest byte address carries bits 31:24
    task automatic wr32(input logic [15:0] a, input logic [31:0] d);
        for (int i = 0; i < 4; i++) wr8(a + 16'(i), d[31 - 8 * i -: 8]);
    endtask

    task automatic rd32(input logic [15:0] a, output logic [31:0] d);
        for (int i = 0; i < 4; i++) rd8(a + 16'(i), d[31 - 8 * i -: 8]);
    endtask

    task automatic poll(input logic [15:0] a);
        for (int k = 0; k < 4000; k++) begin
            rd8(a, b);
            if (!b[7] || b[6]) return;
        end
        n_mismatch++;
        tally_and_finish();
    endtask

    function automatic void fill(input logic [11:0] r, input logic v);
        for (int k = 0; k < 4; k++) exp_e[k] = {4'(k + 1), 4'h0, r, r ^ 12'hA5A};
        exp_e[0][31] = v;
    endfunction

    task automatic load(input logic [11:0] r, input logic v);
        fill(r, v);
        for (int k = 0; k < 4; k++) wr32(16'h0420 + 16'(4 * k), exp_e[k]);
    endtask

    task automatic zero_ent;
        for (int k = 0; k < 4; k++) wr32(16'h0420 + 16'(4 * k), 32'h0000_0000);
    endtask

    task automatic check_ent;
        for (int k = 0; k < 4; k++) begin
            rd32(16'h0420 + 16'(4 * k), w);
            `CHK("entry word", exp_e[k], w)
        end
    endtask

    task automatic sm_op(input logic [5:0] idx, input logic tbl, input logic rdb);
        wr8(16'h041D, {2'b00, idx});
        wr8(16'h041F, {6'b10_0000, tbl, rdb});
        poll(16'h041F);
        `CHK("static go", {6'h00, tbl, rdb}, b)
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk_i);
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rst_b_i = 1'b1;
        rd32(16'h0418, w);
        `CHK("ctrl reset", 32'h0000_0000, w)
        wr32(16'h0414, 32'hA5C3_1E77);
        rd32(16'h0414, w);
        `CHK("key low", 32'hA5C3_1E77, w)
        wr32(16'h0410, 32'hFFFF_FFFF);
        rd32(16'h0410, w);
        `CHK("key high", 32'h807F_FFFF, w)
        wr8(16'h0430, 8'hFF);
        rd8(16'h0430, b);
        `CHK("unmapped", 8'h00, b)
        // table memories power up unknown: mark every row invalid first
        wr32(16'h0420, 32'h0000_0000);
        for (int r = 0; r < 4096; r++) begin
            wr8(16'h0416, 8'(r >> 8));
            wr8(16'h0417, 8'(r));
            wr8(16'h041B, 8'h85);
        end
        load(12'h777, 1'b0);
        wr8(16'h041B, 8'h81);
        poll(16'h041B);
        zero_ent();
        wr8(16'h041B, 8'h82);
        poll(16'h041B);
        check_ent();
        foreach (rows[i]) begin
            load(rows[i], 1'b1);
            wr32(16'h0414, {20'hFFFFF, rows[i]});
            wr8(16'h041B, 8'h85);
            poll(16'h041B);
        end
        foreach (rows[i]) begin
            zero_ent();
            wr32(16'h0414, {20'h00000, rows[i]});
            wr8(16'h041B, 8'h86);
            poll(16'h041B);
            fill(rows[i], 1'b1);
            check_ent();
        end
        hits = 0;
        wr8(16'h041B, 8'h83);
        for (int g = 0; g < 8; g++) begin
            poll(16'h041B);
            if (!b[7]) break;
            `CHK("entry ready", 8'hE3, b)
            fill(rows[hits % 3], 1'b1);
            check_ent();
            hits++;
        end
        `CHK("search end", 8'h23, b)
        `CHK("hit count", 3, hits)
        rd32(16'h0418, w);
        `CHK("valid count", 32'h0003_0023, w)
        wr8(16'h0419, 8'hFF);
        wr8(16'h041A, 8'hFF);
        rd32(16'h0418, w);
        `CHK("count read only", 32'h0003_0023, w)
        load(12'h103, 1'b0);
        sm_op(6'h03, 1'b0, 1'b0);
        load(12'h10F, 1'b0);
        sm_op(6'h0F, 1'b0, 1'b0);
        load(12'h223, 1'b0);
        sm_op(6'h23, 1'b1, 1'b0);
        load(12'h203, 1'b0);
        sm_op(6'h03, 1'b1, 1'b0);
        zero_ent();
        sm_op(6'h33, 1'b0, 1'b1);
        fill(12'h103, 1'b0);
        check_ent();
        for (int m = 0; m < 2; m++) begin
            zero_ent();
            sm_op(m ? 6'h03 : 6'h23, 1'b1, 1'b1);
            fill(m ? 12'h203 : 12'h223, 1'b0);
            exp_e[0] = 32'h0000_0000;
            exp_e[2] = 32'h0000_0000;
            exp_e[3] = 32'h0000_0000;
            check_ent();
        end
        zero_ent();
        sm_op(6'h0F, 1'b0, 1'b1);
        fill(12'h10F, 1'b0);
        check_ent();
        rd32(16'h041C, w);
        `CHK("static ctrl", 32'h000F_0001, w)
        tally_and_finish();
    end
endmodule
